/* shared/netdiag_pkg.sv */
// constants and types shared by the node start-up and diagnostic block
package netdiag_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_SETUP = 8'h04;
  localparam logic [7:0] OFS_STATION = 8'h08;
  localparam logic [7:0] OFS_TENTATIVE = 8'h0c;
  localparam logic [7:0] OFS_NEXT_STATION = 8'h10;
  localparam logic [7:0] OFS_DIAG = 8'h14;
  localparam logic [7:0] OFS_COMMAND = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  // config and setup field positions
  localparam int BIT_JOIN_ENABLE = 5;
  localparam int BIT_TIMEOUT_LOW = 0;
  localparam int BIT_TIMEOUT_HIGH = 1;
  localparam int BIT_SHORT_REFUSAL = 2;
  // diagnostic flag positions (also bit positions in diag register)
  localparam int FLAG_NEW_NEXT = 1;
  localparam int FLAG_PROBE_MATCH = 2;
  localparam int FLAG_EXCESS_REFUSAL = 3;
  localparam int FLAG_TOKEN_SEEN = 4;
  localparam int FLAG_RX_ACTIVITY = 5;
  localparam int FLAG_DUPLICATE = 6;
  localparam int FLAG_SELF_REBUILD = 7;
  localparam int FLAG_COUNT = 8;
  // status register field positions
  localparam int ST_TX_AVAILABLE = 0;
  localparam int ST_CORE_AWAKE = 1;
  localparam int ST_JOINED = 2;
  localparam int ST_DUP_WINDOW_DONE = 3;
  localparam int ST_BUS_SELECTED = 4;
  // reset values
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_SETUP = 8'h00;
  localparam logic [7:0] RST_STATION = 8'h00;
  // command codes written to the command register
  localparam logic [7:0] CMD_FLAG_CLEAR = 8'h01;
  localparam logic [7:0] CMD_DISABLE_TX = 8'h02;
  localparam logic [7:0] CMD_ENABLE_TX = 8'h03;
  // buffer ram start-up writes
  localparam int RAM_AW = 11;
  localparam logic [7:0] RAM_PATTERN = 8'hd1;
  localparam logic [RAM_AW-1:0] RAM_ADDR_PATTERN = 11'h000;
  localparam logic [RAM_AW-1:0] RAM_ADDR_STATION = 11'h001;
  // refusal limits, held as terminal counts
  localparam logic [6:0] REFUSAL_LAST_LONG = 7'h7f;  // 128 refusals
  localparam logic [6:0] REFUSAL_LAST_SHORT = 7'h03; // 4 refusals
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int DUP_WINDOW_SHORT_MS = 6720;
  localparam int DUP_WINDOW_LONG_MS = 13440;
  // start-up sequence states
  typedef enum logic [4:0] {
    S_SLEEP = 5'b00001,
    S_RAM_PATTERN = 5'b00010,
    S_RAM_STATION = 5'b00100,
    S_AWAKE = 5'b01000,
    S_JOINED = 5'b10000
  } node_state_type;
endpackage

/* design/tick_div.sv */
// divider giving a one-cycle enable pulse every div cycles
`timescale 1ns/1ps
`default_nettype none
module tick_div #(
  parameter int unsigned DIV = 100000
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // control and tick
  input wire logic run_in,
  output logic tick_out
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt_q;

  // free count while run, restart when idle
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || !run_in) begin
      cnt_q <= '0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= (cnt_q == LAST);
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + CW'(1);
    end
  end
endmodule
`default_nettype wire

/* design/flag_bank.sv */
// bank of sticky flags where a set beats a clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module flag_bank #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // set and clear per flag
  input wire logic [W-1:0] set_in,
  input wire logic [W-1:0] clr_in,
  output logic [W-1:0] flags_out
);
  // hold until cleared, set wins
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      flags_out <= '0;
    end else begin
      flags_out <= (flags_out & ~clr_in) | set_in;
    end
  end
endmodule
`default_nettype wire

/* design/node_diag.sv */
// node start-up sequencing and network diagnostic flags
//
// What this block does
// - odd-address write then odd-address read selects the host bus type.
// - station number zero keeps the core asleep: no tokens, no rebuilds.
// - nonzero station wakes core; joining waits for transmit join enable.
// - duplicate station flag sets only while awake, before joining; window status ends 6.72 s, 13.44 s unless both selects.
// - duplicate check compares station with token destination, watches response.
// - diagnostic status read clears duplicate station flag.
// - joining the network starts a rebuild and sets self rebuild flag.
// - tentative station write arms probe; matching response sets probe flag.
// - probe ignores own successor; next station register shows it instead.
// - own token reception timer expiry starts rebuild, sets self rebuild.
// - diagnostic status read clears self rebuild flag.
// - config bit 5 enables transmit and lets the node join.
// - high level on serial receive input sets receive activity flag.
// - any token not sent by this node sets token seen flag.
// - 128 refused enquiries, or 4 when short, set excess refusal flag.
// - after disable transmitter, next token received sets transmitter available.
// - flag clear command clears excess refusal; counter wraps for next limit.
// - new next station flag marks a change of next logical node.
// - station write puts d1 at ram 0 and station at ram 1.
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module node_diag
  import netdiag_pkg::*;
#(
  parameter int unsigned TICK_DIV = netdiag_pkg::TICK_CYCLES,
  parameter int unsigned DUP_SHORT_TICKS = netdiag_pkg::DUP_WINDOW_SHORT_MS,
  parameter int unsigned DUP_LONG_TICKS = netdiag_pkg::DUP_WINDOW_LONG_MS
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // network events from the link engine
  input wire logic serial_rx_input_in,
  input wire logic token_in,
  input wire logic [7:0] token_dest_in,
  input wire logic token_own_in,
  input wire logic token_response_in,
  input wire logic token_to_us_in,
  input wire logic refusal_in,
  input wire logic tx_done_in,
  input wire logic rx_timer_expired_in,
  input wire logic [7:0] next_station_in,
  // core control toward the link engine
  output logic core_awake_out,
  output logic join_network_out,
  output logic rebuild_start_out,
  output logic transmitter_available_out,
  output logic excess_refusal_irq_out,
  output logic bus_selected_out,
  // buffer ram write port
  output logic ram_we_out,
  output logic [netdiag_pkg::RAM_AW-1:0] ram_addr_out,
  output logic [7:0] ram_wdata_out
);
  import netdiag_pkg::*;

  localparam logic [13:0] WIN_SHORT = 14'(DUP_SHORT_TICKS - 1);
  localparam logic [13:0] WIN_LONG = 14'(DUP_LONG_TICKS - 1);

  typedef struct packed {
    node_state_type st;
    logic [7:0] config_reg;
    logic [7:0] setup_reg;
    logic [7:0] station_number_reg;
    logic [7:0] tentative_reg;
    logic [7:0] next_seen;
    logic [7:0] rdata;
    logic ram_we;
    logic [RAM_AW-1:0] ram_addr;
    logic [7:0] ram_wdata;
    logic [6:0] refusal_cnt;
    logic ta;
    logic abandon;
    logic odd_wr_seen;
    logic bus_sel;
    logic rebuild;
    logic [13:0] win_cnt;
    logic win_done;
    logic [7:0] last_dest;
    logic last_own;
    logic last_valid;
    logic probe_armed;
    logic awake;
  } state_type;

  state_type s_q, s_d;
  logic [FLAG_COUNT-1:0] flag_set, flag_clr, flags;
  logic tick;
  logic wr_cmd, diag_rd, odd_acc;
  logic transmit_join_enable;
  logic timeout_select_low, timeout_select_high, short_refusal_limit;
  logic dup_hit, probe_hit;
  logic refusal_last;
  logic [7:0] status_word;

  // millisecond enable for the duplicate check window
  tick_div #(
    .DIV(TICK_DIV)
  ) u_tick (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .run_in(s_q.st == S_AWAKE),
    .tick_out(tick)
  );

  // sticky diagnostic flags
  flag_bank #(
    .W(FLAG_COUNT)
  ) u_flags (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .set_in(flag_set),
    .clr_in(flag_clr),
    .flags_out(flags)
  );

  // decoded fields and strobes
  assign transmit_join_enable = s_q.config_reg[BIT_JOIN_ENABLE];
  assign timeout_select_low = s_q.setup_reg[BIT_TIMEOUT_LOW];
  assign timeout_select_high = s_q.setup_reg[BIT_TIMEOUT_HIGH];
  assign short_refusal_limit = s_q.setup_reg[BIT_SHORT_REFUSAL];
  assign wr_cmd = reg_wr_in && (reg_addr_in == OFS_COMMAND);
  assign diag_rd = reg_rd_in && (reg_addr_in == OFS_DIAG);
  assign odd_acc = reg_addr_in[0];

  // response to a token aimed at our own station, seen before joining
  assign dup_hit = token_response_in && s_q.last_valid && !s_q.last_own
    && (s_q.st == S_AWAKE)
    && (s_q.last_dest == s_q.station_number_reg);

  // response to a token aimed at the probe value, not our own token
  assign probe_hit = token_response_in && s_q.probe_armed
    && s_q.last_valid && !s_q.last_own
    && (s_q.last_dest == s_q.tentative_reg);

  // refusal that reaches the chosen limit, kept apart from the flag terms
  assign refusal_last = refusal_in && (s_q.st == S_JOINED)
    && (s_q.refusal_cnt == (short_refusal_limit ? REFUSAL_LAST_SHORT
    : REFUSAL_LAST_LONG));

  // status word
  always_comb begin
    status_word = 8'h00;
    status_word[ST_TX_AVAILABLE] = s_q.ta;
    status_word[ST_CORE_AWAKE] = (s_q.st != S_SLEEP);
    status_word[ST_JOINED] = (s_q.st == S_JOINED);
    status_word[ST_DUP_WINDOW_DONE] = s_q.win_done;
    status_word[ST_BUS_SELECTED] = s_q.bus_sel;
  end

  // flag set and clear terms
  always_comb begin
    flag_set = '0;
    flag_clr = '0;
    flag_set[FLAG_RX_ACTIVITY] = serial_rx_input_in;
    flag_set[FLAG_TOKEN_SEEN] = token_in && !token_own_in;
    flag_set[FLAG_DUPLICATE] = dup_hit;
    flag_set[FLAG_PROBE_MATCH] = probe_hit;
    flag_set[FLAG_NEW_NEXT] = (s_q.st == S_JOINED)
      && (next_station_in != s_q.next_seen);
    flag_set[FLAG_SELF_REBUILD] = s_d.rebuild;
    flag_set[FLAG_EXCESS_REFUSAL] = refusal_last;
    // read of diag status clears the read-sensitive flags
    if (diag_rd) begin
      flag_clr[FLAG_DUPLICATE] = 1'b1;
      flag_clr[FLAG_SELF_REBUILD] = 1'b1;
      flag_clr[FLAG_RX_ACTIVITY] = 1'b1;
      flag_clr[FLAG_TOKEN_SEEN] = 1'b1;
      flag_clr[FLAG_NEW_NEXT] = 1'b1;
    end
    if (wr_cmd && reg_wdata_in == CMD_FLAG_CLEAR) begin
      flag_clr[FLAG_EXCESS_REFUSAL] = 1'b1;
    end
    if (reg_wr_in && reg_addr_in == OFS_TENTATIVE) begin
      flag_clr[FLAG_PROBE_MATCH] = 1'b1;
    end
  end

  // next state of everything
  always_comb begin
    s_d = s_q;
    s_d.ram_we = 1'b0;
    s_d.rebuild = 1'b0;

    // host bus type chosen by odd write followed by odd read
    if (!s_q.bus_sel && reg_wr_in && odd_acc) begin
      s_d.odd_wr_seen = 1'b1;
    end
    if (!s_q.bus_sel && reg_rd_in && odd_acc && s_q.odd_wr_seen) begin
      s_d.bus_sel = 1'b1;
    end

    // register writes
    if (reg_wr_in && !odd_acc) begin
      case (reg_addr_in)
        OFS_CONFIG: s_d.config_reg = reg_wdata_in;
        OFS_SETUP: s_d.setup_reg = reg_wdata_in;
        OFS_STATION: s_d.station_number_reg = reg_wdata_in;
        OFS_TENTATIVE: begin
          s_d.tentative_reg = reg_wdata_in;
          s_d.probe_armed = 1'b1;
        end
        default: ;
      endcase
    end

    // read data, one cycle later; odd or unmapped reads give zero
    s_d.rdata = 8'h00;
    if (reg_rd_in && !odd_acc) begin
      case (reg_addr_in)
        OFS_CONFIG: s_d.rdata = s_q.config_reg;
        OFS_SETUP: s_d.rdata = s_q.setup_reg;
        OFS_STATION: s_d.rdata = s_q.station_number_reg;
        OFS_TENTATIVE: s_d.rdata = s_q.tentative_reg;
        OFS_NEXT_STATION: s_d.rdata = next_station_in;
        OFS_DIAG: s_d.rdata = flags;
        OFS_STATUS: s_d.rdata = status_word;
        default: s_d.rdata = 8'h00;
      endcase
    end

    // remember the latest token for pairing with its response
    if (token_in) begin
      s_d.last_dest = token_dest_in;
      s_d.last_own = token_own_in;
      s_d.last_valid = 1'b1;
    end

    // transmit commands and transmitter available
    if (wr_cmd && reg_wdata_in == CMD_ENABLE_TX) begin
      s_d.ta = 1'b0;
      s_d.abandon = 1'b0;
    end
    if (wr_cmd && reg_wdata_in == CMD_DISABLE_TX && !s_q.ta) begin
      s_d.abandon = 1'b1;
    end
    if (tx_done_in && !s_q.ta) begin
      s_d.ta = 1'b1;
    end
    if (token_to_us_in && s_q.abandon && s_q.st == S_JOINED) begin
      s_d.ta = 1'b1;
      s_d.abandon = 1'b0;
    end

    // refusal counter wraps at the chosen limit
    if (refusal_in && s_q.st == S_JOINED) begin
      if (refusal_last) begin
        s_d.refusal_cnt = 7'h00;
      end else begin
        s_d.refusal_cnt = s_q.refusal_cnt + 7'h01;
      end
    end

    // start-up sequence
    case (s_q.st)
      S_SLEEP: begin
        // nothing runs while the station number is zero
        if (s_q.station_number_reg != 8'h00) begin
          s_d.st = S_RAM_PATTERN;
        end
      end
      S_RAM_PATTERN: begin
        s_d.ram_we = 1'b1;
        s_d.ram_addr = RAM_ADDR_PATTERN;
        s_d.ram_wdata = RAM_PATTERN;
        s_d.st = S_RAM_STATION;
      end
      S_RAM_STATION: begin
        s_d.ram_we = 1'b1;
        s_d.ram_addr = RAM_ADDR_STATION;
        s_d.ram_wdata = s_q.station_number_reg;
        s_d.st = S_AWAKE;
        s_d.win_cnt = 14'h0000;
        s_d.win_done = 1'b0;
      end
      S_AWAKE: begin
        // duplicate check window runs until joining
        if (tick && !s_q.win_done) begin
          if (s_q.win_cnt == ((timeout_select_low && timeout_select_high)
              ? WIN_SHORT : WIN_LONG)) begin
            s_d.win_done = 1'b1;
          end else begin
            s_d.win_cnt = s_q.win_cnt + 14'h0001;
          end
        end
        if (transmit_join_enable) begin
          s_d.st = S_JOINED;
          s_d.rebuild = 1'b1;
          s_d.next_seen = next_station_in;
          s_d.refusal_cnt = 7'h00;
        end
      end
      S_JOINED: begin
        s_d.next_seen = next_station_in;
        if (rx_timer_expired_in) begin
          s_d.rebuild = 1'b1;
        end
        if (!transmit_join_enable) begin
          s_d.st = S_AWAKE;
          s_d.rebuild = 1'b0;
        end
      end
      default: s_d.st = S_SLEEP;
    endcase

    // a new station number restarts the sequence, zero puts it to sleep
    if (reg_wr_in && !odd_acc && reg_addr_in == OFS_STATION) begin
      s_d.rebuild = 1'b0;
      if (reg_wdata_in == 8'h00) begin
        s_d.st = S_SLEEP;
      end else begin
        s_d.st = S_RAM_PATTERN;
      end
    end
    // registered awake level for the core control output
    s_d.awake = (s_d.st == S_AWAKE) || (s_d.st == S_JOINED);
  end

  // one register for the whole state
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      s_q <= '0;
      s_q.st <= S_SLEEP;
      s_q.config_reg <= RST_CONFIG;
      s_q.setup_reg <= RST_SETUP;
      s_q.station_number_reg <= RST_STATION;
      s_q.ta <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata_out = s_q.rdata;
  assign core_awake_out = s_q.awake;
  assign join_network_out = s_q.st[4];
  assign rebuild_start_out = s_q.rebuild;
  assign transmitter_available_out = s_q.ta;
  assign excess_refusal_irq_out = flags[FLAG_EXCESS_REFUSAL];
  assign bus_selected_out = s_q.bus_sel;
  assign ram_we_out = s_q.ram_we;
  assign ram_addr_out = s_q.ram_addr;
  assign ram_wdata_out = s_q.ram_wdata;
endmodule
`default_nettype wire

/* testbench/netdiag_checker.sv */
// port checks for the start-up and diagnostic block
`timescale 1ns/1ps
`default_nettype none
module netdiag_checker (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // network events
  input wire logic refusal_in,
  input wire logic rx_timer_expired_in,
  // core control and ram port
  input wire logic core_awake_out,
  input wire logic join_network_out,
  input wire logic rebuild_start_out,
  input wire logic excess_refusal_irq_out,
  input wire logic bus_selected_out,
  input wire logic ram_we_out,
  input wire logic [netdiag_pkg::RAM_AW-1:0] ram_addr_out,
  input wire logic [7:0] ram_wdata_out
);
  import netdiag_pkg::*;
  logic stn_wr;
  logic clr_cmd;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // decoded host writes
  assign stn_wr = reg_wr_in && reg_addr_in == OFS_STATION;
  assign clr_cmd = reg_wr_in && reg_addr_in == OFS_COMMAND
    && reg_wdata_in == CMD_FLAG_CLEAR;
  AST_RAM_PATTERN: assert property (stn_wr && reg_wdata_in != 8'h00 |=>
    ##1 ram_we_out && ram_addr_out == RAM_ADDR_PATTERN
    && ram_wdata_out == RAM_PATTERN) else $error("pattern write missing");
  AST_RAM_STATION: assert property (stn_wr && reg_wdata_in != 8'h00 |=>
    ##2 ram_we_out && ram_addr_out == RAM_ADDR_STATION
    && ram_wdata_out == $past(reg_wdata_in, 3))
    else $error("station write missing");
  AST_WAKE: assert property (stn_wr && reg_wdata_in != 8'h00 |=>
    ##2 core_awake_out) else $error("core did not wake");
  AST_SLEEP: assert property (stn_wr && reg_wdata_in == 8'h00 |=>
    !core_awake_out && !join_network_out) else $error("core not asleep");
  AST_NO_JOIN: assert property (!core_awake_out |-> !join_network_out)
    else $error("joined while asleep");
  AST_JOIN_REBUILD: assert property ($rose(join_network_out) |->
    rebuild_start_out) else $error("join without rebuild");
  AST_TIMER_REBUILD: assert property (join_network_out
    && rx_timer_expired_in && !stn_wr |=> rebuild_start_out)
    else $error("timer expiry without rebuild");
  AST_RD_IDLE: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data outside its cycle");
  AST_FLAG_CLEAR: assert property (clr_cmd && !refusal_in |=>
    !excess_refusal_irq_out) else $error("refusal flag not cleared");
  AST_BUS_HOLD: assert property (bus_selected_out |=> bus_selected_out)
    else $error("bus selection lost");
  // main scenarios reached
  cover property ($rose(join_network_out));
  cover property ($rose(excess_refusal_irq_out));
  cover property (ram_we_out ##1 ram_we_out);
endmodule
bind node_diag netdiag_checker i_chk (.*);
`default_nettype wire

/* testbench/net_partner.sv */
// far-side model: link engine reporting network events
`timescale 1ns/1ps
`default_nettype none
module net_partner (
  // clock
  input wire logic ref_clk_in,
  // network events toward the block
  output logic serial_rx_input_in,
  output logic token_in,
  output logic [7:0] token_dest_in,
  output logic token_own_in,
  output logic token_response_in,
  output logic token_to_us_in,
  output logic refusal_in,
  output logic tx_done_in,
  output logic rx_timer_expired_in,
  output logic [7:0] next_station_in
);
  // quiet network at time zero
  initial begin
    {serial_rx_input_in, token_in, token_own_in, token_response_in} = 4'h0;
    {token_to_us_in, refusal_in, tx_done_in, rx_timer_expired_in} = 4'h0;
    token_dest_in = 8'h00;
    next_station_in = 8'h00;
  end
  // one token frame, answered after lag cycles when resp is set
  task automatic token(input logic [7:0] d, input logic own,
                       input logic resp, input int lag);
    @(posedge ref_clk_in);
    serial_rx_input_in <= 1'b1;
    token_in <= 1'b1;
    token_dest_in <= d;
    token_own_in <= own;
    @(posedge ref_clk_in);
    serial_rx_input_in <= 1'b0; // line idles low between frames
    token_in <= 1'b0;
    token_dest_in <= ~d; // stale destination is not held
    repeat (lag) @(posedge ref_clk_in);
    token_response_in <= resp;
    @(posedge ref_clk_in);
    token_response_in <= 1'b0;
  endtask
  // single event pulse: 0 refusal, 1 token to us, 2 timer, else tx done
  task automatic pulse(input int k);
    @(posedge ref_clk_in);
    case (k)
      0: refusal_in <= 1'b1;
      1: token_to_us_in <= 1'b1;
      2: rx_timer_expired_in <= 1'b1;
      default: tx_done_in <= 1'b1;
    endcase
    @(posedge ref_clk_in);
    {refusal_in, token_to_us_in, rx_timer_expired_in, tx_done_in} <= 4'h0;
  endtask
  // new successor reported by the ring
  task automatic set_next(input logic [7:0] v);
    @(posedge ref_clk_in);
    next_station_in <= v;
  endtask
endmodule
`default_nettype wire

/* testbench/node_diag_test.sv */
// self-checking bench for the start-up and diagnostic block
`timescale 1ns/1ps
`default_nettype none
module node_diag_test;
  import netdiag_pkg::*;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out, token_dest_in, next_station_in, st;
  logic serial_rx_input_in, token_in, token_own_in, token_response_in;
  logic token_to_us_in, refusal_in, tx_done_in, rx_timer_expired_in;
  logic core_awake_out, join_network_out, rebuild_start_out;
  logic transmitter_available_out, excess_refusal_irq_out;
  logic bus_selected_out, ram_we_out;
  logic [RAM_AW-1:0] ram_addr_out;
  logic [7:0] ram_wdata_out;
  int m_diag = 0;
  int n_mismatch = 0;
  int samples_checked = 0;
  int i;
  net_partner p (.*);
  node_diag #(.TICK_DIV(4), .DUP_SHORT_TICKS(3), .DUP_LONG_TICKS(6))
    i_dut (.*);
  // 100 MHz clock
  always #5 ref_clk_in = ~ref_clk_in;
  // compare and count
  task automatic check(input string s, input logic [7:0] seen,
                       input int exp);
    samples_checked++;
    if (seen !== 8'(exp)) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", s, 8'(exp), seen);
    end
  endtask
  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  // one-cycle register read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, input int exp);
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1 check("rdata", reg_rdata_out, exp);
  endtask
  // diag read against the model; read keeps probe and refusal bits
  task automatic rd_diag();
    rd(OFS_DIAG, m_diag);
    m_diag = m_diag & 8'h0c;
  endtask
  // refusal burst then flag level
  task automatic refuse(input int n, input int exp);
    repeat (n) p.pulse(0);
    @(posedge ref_clk_in);
    #1 check("irq", excess_refusal_irq_out, exp);
  endtask
  // verdict
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    n_mismatch++;
    stop_test();
  end
  // main sequence
  initial begin
    void'($urandom(7));
    st = 8'($urandom_range(200, 1));
    repeat (2) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    rd(OFS_STATUS, 8'h01);
    check("bus", bus_selected_out, 0);
    wr(8'h01, 8'h5a);
    rd(8'h01, 0);
    @(posedge ref_clk_in);
    #1 check("bus", bus_selected_out, 1);
    wr(OFS_CONFIG, 8'h20);
    repeat (3) @(posedge ref_clk_in);
    #1 check("join", join_network_out, 0);
    wr(OFS_CONFIG, 8'h00);
    wr(OFS_SETUP, 8'h00);
    wr(OFS_STATION, st);
    @(posedge ref_clk_in);
    #1 check("ram0", ram_wdata_out, 8'hd1);
    @(posedge ref_clk_in);
    #1 check("ram1", ram_wdata_out, st);
    @(posedge ref_clk_in);
    #1 check("awake", core_awake_out, 1);
    repeat (12) @(posedge ref_clk_in);
    rd(OFS_STATUS, 8'h13);
    check("join", join_network_out, 0);
    repeat (24) @(posedge ref_clk_in);
    rd(OFS_STATUS, 8'h1b);
    p.token(st, 1'b0, 1'b1, 3);
    m_diag |= 8'h70;
    rd_diag();
    rd_diag();
    p.token(st ^ 8'h80, 1'b0, 1'b1, 0);
    p.token(st, 1'b1, 1'b0, 0);
    m_diag |= 8'h30;
    rd_diag();
    wr(OFS_TENTATIVE, st + 8'd1);
    p.token(st + 8'd1, 1'b0, 1'b1, 0);
    m_diag |= 8'h34;
    rd_diag();
    wr(OFS_CONFIG, 8'h20);
    for (i = 0; i < 8 && join_network_out !== 1'b1; i++) begin
      @(posedge ref_clk_in);
      #1;
    end
    if (join_network_out !== 1'b1) begin
      n_mismatch++;
      stop_test();
    end
    m_diag |= 8'h80;
    rd_diag();
    rd_diag();
    p.pulse(2);
    m_diag |= 8'h80;
    rd_diag();
    p.set_next(st + 8'd2);
    m_diag |= 8'h02;
    rd_diag();
    rd(OFS_NEXT_STATION, st + 8'd2);
    wr(OFS_SETUP, 8'h04);
    refuse(3, 0);
    refuse(1, 1);
    wr(OFS_COMMAND, CMD_FLAG_CLEAR);
    refuse(0, 0);
    refuse(4, 1);
    wr(OFS_COMMAND, CMD_FLAG_CLEAR);
    wr(OFS_SETUP, 8'h00);
    refuse(127, 0);
    refuse(1, 1);
    m_diag |= 8'h08;
    rd_diag();
    wr(OFS_COMMAND, CMD_ENABLE_TX);
    rd(OFS_STATUS, 8'h1e);
    p.pulse(3);
    rd(OFS_STATUS, 8'h1f);
    wr(OFS_COMMAND, CMD_ENABLE_TX);
    wr(OFS_COMMAND, CMD_DISABLE_TX);
    rd(OFS_STATUS, 8'h1e);
    p.pulse(1);
    rd(OFS_STATUS, 8'h1f);
    check("ta", transmitter_available_out, 1);
    // short duplicate window with both timeout selects set
    wr(OFS_CONFIG, 8'h00);
    wr(OFS_SETUP, 8'h03);
    wr(OFS_STATION, st);
    repeat (8) @(posedge ref_clk_in);
    rd(OFS_STATUS, 8'h13);
    repeat (8) @(posedge ref_clk_in);
    rd(OFS_STATUS, 8'h1b);
    wr(OFS_STATION, 8'h00);
    repeat (2) @(posedge ref_clk_in);
    #1 check("awake", core_awake_out, 0);
    stop_test();
  end
endmodule
`default_nettype wire
